/* hdl/adcc_ctrl.sv */
// Notes on behaviour
// - the end-of-conversion interrupt only rises while the interrupt enable bit is 1.
// - writing 1 to the start bit starts conversion on the selected channel or group.
// - writing 0 to the start bit aborts any conversion and returns to idle.
// - in single mode the start bit clears itself when the one channel is done.
// - in scan mode conversion repeats over the group until the start bit is cleared.
// - the mode bit selects single mode at 0 and scan mode at 1.
// - in single mode the channel field is the index of the one input converted.
// - in scan mode the upper channel bits pick the group base and the lower bits the count minus one.
// - enable, start, mode and channel bits reset to 0 and are read/write.
// - a finished single conversion stores its result per channel and sets the end flag.
// - a finished scan pass sets the end flag and restarts at the group's first channel.
module adcc_ctrl
  import adcc_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_nrst,
  input  wire logic [31:0]              i_haddr,
  input  wire logic [1:0]               i_htrans,
  input  wire logic                     i_hwrite,
  input  wire logic [2:0]               i_hsize,
  input  wire logic [31:0]              i_hwdata,
  input  wire logic                     i_hsel,
  input  wire logic                     i_hready,
  output logic      [31:0]              o_hrdata,
  output logic                          o_hreadyout,
  output logic                          o_hresp,
  input  wire logic                     i_core_done,
  input  wire logic [adcc_pkg::RES_W-1:0] i_core_result,
  output adcc_pkg::adcc_core_req_t      o_core_req,
  output logic                          o_conv_end_irq
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  adcc_ctrl_t            ctrl_ff,    nxt_ctrl;
  logic                  flag_ff,    nxt_flag;
  logic                  mask_ff,    nxt_mask;
  adcc_state_t           state_ff,   nxt_state;
  logic [3:0]            cur_ff,     nxt_cur;
  logic [RES_W-1:0]      res_ff [NUM_CH];
  logic [3:0]            rsel_ff,    nxt_rsel;
  logic                  wr_ff,      nxt_wr;
  logic                  rd_ff,      nxt_rd;
  logic [3:0]            addr_ff,    nxt_addr;
  logic [31:0]           rdata_ff,   nxt_rdata;
  logic                  irq_ff,     nxt_irq;
  adcc_core_req_t        req_ff,     nxt_req;
  logic                  flag_read_ff, nxt_flag_read;
  logic                  hit_ff,     nxt_hit;
  logic [RES_W-1:0]      nxt_res [NUM_CH];

  // register map, one aligned word each:
  //   csr    : end flag, irq enable, start, scan, channel field
  //   mask   : bit 0 gates the interrupt line on top of the enable bit
  //   result : result of the channel named by the result select word
  //   select : which channel's result the result word shows
  // anything else reads 0 and ignores writes

  // only the first four words are mapped; without the upper-bit check
  // every sixteen-byte block would alias onto the registers
  function automatic logic reg_hit(input logic [31:0] a);
    reg_hit = (a[31:4] == 28'h0000000) & (a[1:0] == 2'b00);
  endfunction : reg_hit

  function automatic logic [3:0] grp_first(input logic scan, input logic [3:0] ch);
    grp_first = scan ? {ch[3:2], 2'b00} : ch;
  endfunction : grp_first

  function automatic logic [7:0] csr_value(input adcc_ctrl_t c, input logic f);
    csr_value = {f, c.irq_enable, c.start, c.scan, c.chan};
  endfunction : csr_value

  ////////////////////////////////////////////////////////////////////////////
  // bus and control
  logic addr_ph;
  logic wr_csr;
  logic done_evt;
  logic pass_end;
  logic single_end;
  logic wr_ok;
  logic flag_clr;
  assign addr_ph  = i_hsel & i_hready & i_htrans[1];
  assign wr_ok    = wr_ff & hit_ff;
  assign wr_csr   = wr_ok & (addr_ff == ADDR_CSR);
  // clearing needs a 0 written after a read that saw the flag at 1
  assign flag_clr = wr_csr & ~i_hwdata[BIT_END_FLAG] & flag_read_ff;
  assign done_evt = (state_ff == ST_CONV) & i_core_done & ctrl_ff.start;
  assign single_end = done_evt & ~ctrl_ff.scan;
  assign pass_end = done_evt & ctrl_ff.scan & (cur_ff[1:0] == ctrl_ff.chan[1:0]);

  // bus capture: the address phase is latched and acted on in the data phase
  always_comb
  begin
    nxt_wr        = addr_ph & i_hwrite;
    nxt_rd        = addr_ph & ~i_hwrite;
    nxt_addr      = addr_ph ? i_haddr[3:0] : addr_ff;
    nxt_hit       = addr_ph ? reg_hit(i_haddr) : hit_ff;
    nxt_rdata     = rdata_ff;
    nxt_flag_read = flag_read_ff;
    // a clear uses up the earlier read; a fresh read of 1 is needed again
    if (flag_clr)
      nxt_flag_read = 1'b0;
    if (addr_ph && !i_hwrite)
    begin
      // fetched at the address phase so the word stands through the data phase
      if (!reg_hit(i_haddr))
        nxt_rdata = 32'h00000000;
      else
      begin
        unique case (i_haddr[3:0])
          ADDR_CSR:    nxt_rdata = {24'h000000, csr_value(ctrl_ff, flag_ff)};
          ADDR_MASK:   nxt_rdata = {31'h00000000, mask_ff};
          ADDR_RESULT: nxt_rdata = {22'h000000, res_ff[rsel_ff]};
          ADDR_CHAN:   nxt_rdata = {28'h0000000, rsel_ff};
          default:     nxt_rdata = 32'h00000000;
        endcase
      end
      // a read in the clearing cycle still counts as having seen the flag
      if (reg_hit(i_haddr) && i_haddr[3:0] == ADDR_CSR)
        nxt_flag_read = flag_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control word, end flag, mask and interrupt
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_flag = flag_ff;
    nxt_mask = mask_ff;
    nxt_rsel = rsel_ff;
    if (wr_csr)
    begin
      nxt_ctrl.irq_enable = i_hwdata[BIT_IRQ_ENABLE];
      nxt_ctrl.start      = i_hwdata[BIT_START];
      nxt_ctrl.scan       = i_hwdata[BIT_SCAN];
      nxt_ctrl.chan       = i_hwdata[3:0];
    end
    if (flag_clr)
      nxt_flag = 1'b0;
    if (wr_ok && addr_ff == ADDR_MASK)
      nxt_mask = i_hwdata[0];
    if (wr_ok && addr_ff == ADDR_CHAN)
      nxt_rsel = i_hwdata[3:0];
    // a finished single conversion beats a start written in the same cycle
    if (single_end)
      nxt_ctrl.start = 1'b0;
    // set wins over clear so no end of conversion is ever lost
    if (single_end || pass_end)
      nxt_flag = 1'b1;
    nxt_irq = nxt_flag & nxt_ctrl.irq_enable & nxt_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result store per channel; data needs no reset, only written on done
  always_comb
  begin
    nxt_res = res_ff;
    if (done_evt)
      nxt_res[cur_ff] = i_core_result;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cur   = cur_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (ctrl_ff.start)
        begin
          nxt_cur   = grp_first(ctrl_ff.scan, ctrl_ff.chan);
          nxt_state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (!ctrl_ff.start)
          nxt_state = ST_IDLE;
        else if (i_core_done)
        begin
          if (!ctrl_ff.scan)
            nxt_state = ST_IDLE;
          else
            nxt_state = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        if (!ctrl_ff.start)
          nxt_state = ST_IDLE;
        else
        begin
          // wrap to the group start after the last channel
          nxt_cur = (cur_ff[1:0] == ctrl_ff.chan[1:0]) ? {ctrl_ff.chan[3:2], 2'b00}
                                                        : cur_ff + 4'h1;
          nxt_state = ST_CONV;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (wr_csr && !i_hwdata[BIT_START])
      nxt_state = ST_IDLE;
    nxt_req.start = (nxt_state == ST_CONV);
    nxt_req.chan  = nxt_cur;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      wr_ff        <= 1'b0;
      rd_ff        <= 1'b0;
      addr_ff      <= 4'h0;
      hit_ff       <= 1'b0;
      rdata_ff     <= 32'h00000000;
      flag_read_ff <= 1'b0;
    end
    else
    begin
      wr_ff        <= nxt_wr;
      rd_ff        <= nxt_rd;
      addr_ff      <= nxt_addr;
      hit_ff       <= nxt_hit;
      rdata_ff     <= nxt_rdata;
      flag_read_ff <= nxt_flag_read;
    end
  end

  // control registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      ctrl_ff <= adcc_ctrl_t'(CSR_RESET[6:0]);
      flag_ff <= CSR_RESET[BIT_END_FLAG];
      mask_ff <= MASK_RESET;
      rsel_ff <= 4'h0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      flag_ff <= nxt_flag;
      mask_ff <= nxt_mask;
      rsel_ff <= nxt_rsel;
      irq_ff  <= nxt_irq;
    end
  end

  // sequencer registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      state_ff <= ST_IDLE;
      cur_ff   <= 4'h0;
      req_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cur_ff   <= nxt_cur;
      req_ff   <= nxt_req;
    end
  end

  // result store
  always_ff @(posedge i_ref_clk)
  begin
    res_ff <= nxt_res;
  end

  assign o_hrdata       = rdata_ff;
  assign o_hreadyout    = 1'b1;
  assign o_hresp        = 1'b0;
  assign o_core_req     = req_ff;
  assign o_conv_end_irq = irq_ff;

endmodule : adcc_ctrl

/* hdl/adcc_pkg.sv */
package adcc_pkg;

  // register byte addresses
  localparam logic [3:0] ADDR_CSR    = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_CHAN   = 4'hc;

  // control/status field positions
  localparam int BIT_END_FLAG   = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_START      = 5;
  localparam int BIT_SCAN       = 4;

  // reset values
  localparam logic [7:0] CSR_RESET  = 8'h00;
  localparam logic [0:0] MASK_RESET = 1'h1;

  localparam int RES_W  = 10;
  localparam int NUM_CH = 16;

  typedef struct packed {
    logic       irq_enable;
    logic       start;
    logic       scan;
    logic [3:0] chan;
  } adcc_ctrl_t;

  typedef struct packed {
    logic       start;
    logic [3:0] chan;
  } adcc_core_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_NEXT = 3'b100
  } adcc_state_t;

endpackage : adcc_pkg

/* verification/adcc_ctrl_assertions.sv */
module adcc_chk
  import adcc_pkg::*;
(
  input wire logic                     i_ref_clk,
  input wire logic                     i_nrst,
  input wire logic [1:0]               i_htrans,
  input wire logic                     i_hwrite,
  input wire logic                     i_hsel,
  input wire logic                     i_hready,
  input wire logic                     i_core_done,
  input wire logic [31:0]              o_hrdata,
  input wire logic                     o_hreadyout,
  input wire logic                     o_hresp,
  input wire adcc_pkg::adcc_core_req_t o_core_req,
  input wire logic                     o_conv_end_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////
  // cycles since last write / done, saturating so old causes age out
  logic       rd_take;
  logic       wr_take;
  logic [2:0] wr_age_ff, done_age_ff, nxt_wr_age, nxt_done_age;
  assign rd_take = i_hsel & i_hready & i_htrans[1] & !i_hwrite;
  assign wr_take = i_hsel & i_hready & i_htrans[1] & i_hwrite;
  always_comb
  begin
    nxt_wr_age   = !i_nrst ? 3'h7 : (wr_take ? 3'h0 : wr_age_ff + {2'h0, wr_age_ff != 3'h7});
    nxt_done_age = !i_nrst ? 3'h7 : (i_core_done ? 3'h0 : done_age_ff + {2'h0, done_age_ff != 3'h7});
  end
  always_ff @(posedge i_ref_clk)
  begin
    wr_age_ff   <= nxt_wr_age;
    done_age_ff <= nxt_done_age;
  end
  ////////////////////////////////////////
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_hready_okay:
    assert property (o_hreadyout && !o_hresp) else $error("bus answer not ready or not okay");
  a_start_cause:
    assert property ($rose(o_core_req.start) |-> wr_age_ff <= 3'h3 || done_age_ff <= 3'h3) else $error("start unprompted");
  a_stop_cause:
    assert property ($fell(o_core_req.start) |-> wr_age_ff <= 3'h3 || done_age_ff <= 3'h2) else $error("stop unprompted");
  a_irq_cause:
    assert property ($rose(o_conv_end_irq) |-> wr_age_ff <= 3'h3 || done_age_ff <= 3'h2) else $error("irq unprompted");
  a_irq_sticky:
    assert property (o_conv_end_irq && wr_age_ff > 3'h3 |=> o_conv_end_irq) else $error("irq dropped without write");
  a_chan_hold:
    assert property (o_core_req.start && $past(o_core_req.start) && $changed(o_core_req.chan) |-> done_age_ff <= 3'h3)
      else $error("channel moved without done");
  a_rdata_hold:
    assert property ($changed(o_hrdata) |-> $past(rd_take)) else $error("read data moved without read");
  a_reset_idle:
    assert property ($rose(i_nrst) |-> !o_core_req.start && !o_conv_end_irq && o_hrdata == 32'h0) else $error("not idle");
endmodule : adcc_chk
bind adcc_ctrl adcc_chk chk_u (.i_ref_clk, .i_nrst, .i_htrans, .i_hwrite, .i_hsel, .i_hready, .i_core_done,
  .o_hrdata, .o_hreadyout, .o_hresp, .o_core_req, .o_conv_end_irq);

/* verification/adcc_ctrl_tb_top.sv */
module adcc_ctrl_tb_top;
  import adcc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk = 1'b0, nrst = 1'b0, hwrite = 1'b0, hsel = 1'b0, done = 1'b0;
  logic [1:0]       htrans = 2'h0;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [RES_W-1:0] res = '0;
  logic             hready, hresp, irq;
  adcc_core_req_t   req;
  int               err_total = 0, comparisons = 0, cyc = 0;
  adcc_ctrl dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_core_done(done), .i_core_result(res), .o_core_req(req),
    .o_conv_end_irq(irq));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // generous ceiling: whole run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    if (seen !== exp)
      err_total++;
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // core reports one finished channel
  task automatic conv_done(input logic [RES_W-1:0] r);
    done <= 1'b1;
    res  <= r;
    @(posedge clk);
    done <= 1'b0;
    tick(3);
  endtask : conv_done
  ////////////////////////////////////////
  initial
  begin
    tick(16);
    nrst <= 1'b1;
    @(posedge clk);
    xfer(ADDR_CSR, 1'b0, 32'h0);
    chk(rd, {24'h0, CSR_RESET});
    xfer(ADDR_MASK, 1'b0, 32'h0);
    chk(rd, {31'h0, MASK_RESET});
    xfer(8'h10, 1'b1, 32'hff);
    xfer(8'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(ADDR_CSR, 1'b1, 32'h5f);
    xfer(ADDR_CSR, 1'b0, 32'h0);
    chk(rd, 32'h5f);
    $display("test reset_rw done");
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      xfer(ADDR_CSR, 1'b1, 32'h60 | ch);
      tick(3);
      chk({27'h0, req}, {27'h0, 1'b1, 4'(ch)});
      conv_done(RES_W'(ch * 37 + 5));
      chk({31'h0, req.start}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      xfer(ADDR_CSR, 1'b0, 32'h0);
      chk(rd, 32'hc0 | ch);
      xfer(ADDR_CHAN, 1'b1, ch);
      xfer(ADDR_RESULT, 1'b0, 32'h0);
      chk(rd, 32'(ch * 37 + 5));
    end
    $display("test single done");
    xfer(ADDR_CSR, 1'b1, 32'h23);
    tick(3);
    conv_done(RES_W'(1));
    chk({31'h0, irq}, 32'h0);
    xfer(ADDR_CSR, 1'b0, 32'h0);
    chk(rd, 32'h83);
    xfer(ADDR_CSR, 1'b1, 32'hc3);
    tick(3);
    chk({31'h0, irq}, 32'h1);
    xfer(ADDR_MASK, 1'b1, 32'h0);
    tick(3);
    chk({31'h0, irq}, 32'h0);
    xfer(ADDR_MASK, 1'b1, 32'h1);
    $display("test irq_gate done");
    xfer(ADDR_CSR, 1'b1, 32'h76);
    tick(3);
    for (int i = 0; i < 5; i++)
    begin
      chk({27'h0, req}, {27'h0, 1'b1, 4'(4 + i % 3)});
      conv_done(RES_W'(i));
    end
    xfer(ADDR_CSR, 1'b0, 32'h0);
    chk(rd, 32'hf6);
    xfer(ADDR_CSR, 1'b1, 32'h56);
    tick(3);
    chk({31'h0, req.start}, 32'h0);
    $display("test scan_abort done");
    close_out();
  end
endmodule : adcc_ctrl_tb_top
